// file: contact_map_pkg.sv
// Purpose: shared constants and types for the contact input function mapper
// Assumes: 50 MHz system clock, AXI4-Lite register access
// Notes: table rows hold one nibble per input, input 1 in the low nibble
package contact_map_pkg;

	// ***************************************************************
	// timing
	// ***************************************************************
	localparam int unsigned CLK_HZ      = 50000000;
	localparam int unsigned HOLD_MS     = 250;
	localparam int unsigned HOLD_CYCLES = CLK_HZ / 1000 * HOLD_MS;

	// ***************************************************************
	// sizes
	// ***************************************************************
	localparam int unsigned NUM_INPUTS  = 8;
	localparam int unsigned MAX_SETTING = 29;
	localparam int unsigned SET_W       = 5;
	localparam int unsigned AXI_ADDR_W  = 4;

	// ***************************************************************
	// register map
	// ***************************************************************
	localparam logic [3:0] OFF_CTRL   = 4'h0;
	localparam logic [3:0] OFF_STATUS = 4'h4;
	localparam logic [3:0] OFF_EVENT  = 4'h8;

	localparam int unsigned CTRL_SET_LSB     = 0;
	localparam int unsigned CTRL_AREA_EN_BIT = 8;
	localparam int unsigned CTRL_RUN_BIT     = 16;
	localparam int unsigned CTRL_MANUAL_BIT  = 17;
	localparam int unsigned CTRL_REMOTE_BIT  = 18;

	localparam int unsigned STAT_LEVEL_LSB = 0;
	localparam int unsigned STAT_MODE_LSB  = 8;
	localparam int unsigned EVENT_W        = 4;

	localparam logic [SET_W-1:0] SET_RESET     = 5'h00;
	localparam logic             AREA_EN_RESET = 1'b0;
	localparam logic             COMM_RUN_RESET    = 1'b0;
	localparam logic             COMM_MANUAL_RESET = 1'b0;
	localparam logic             COMM_REMOTE_RESET = 1'b0;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ***************************************************************
	// input functions
	// ***************************************************************
	typedef enum logic [3:0] {
		FN_NONE    = 4'b0000,
		FN_RUN     = 4'b0001,
		FN_MANUAL  = 4'b0010,
		FN_REMOTE  = 4'b0011,
		FN_UNLOCK  = 4'b0100,
		FN_DS1     = 4'b0101,
		FN_DS2     = 4'b0110,
		FN_SOAK    = 4'b0111,
		FN_AREA8   = 4'b1000,
		FN_AREA2   = 4'b1001,
		FN_AREASET = 4'b1010,
		FN_OPMODE  = 4'b1011
	} func_e;

	localparam logic [31:0] ASSIGN_TABLE [0:29] = '{
		32'h00000000, 32'h24BBA888, 32'h34BBA888, 32'h54BBA888,
		32'h74BBA888, 32'h14BBA888, 32'h32BBA888, 32'h52BBA888,
		32'h72BBA888, 32'h12BBA888, 32'h53BBA888, 32'h73BBA888,
		32'h13BBA888, 32'h7524A888, 32'h1524A888, 32'h1724A888,
		32'h5324A888, 32'h7324A888, 32'h1324A888, 32'h7234A888,
		32'h1234A888, 32'h1734A888, 32'h7532A888, 32'h1532A888,
		32'h1732A888, 32'h0053A888, 32'hBB3214A9, 32'h00BBA888,
		32'h653214A9, 32'hBB000065
	};

	// ***************************************************************
	// carriers
	// ***************************************************************
	typedef struct packed {
		logic       run;
		logic       manual;
		logic       remote;
		logic       soak_stop;
		logic [2:0] area;
		logic [1:0] op_mode;
	} mode_s;

	typedef struct packed {
		logic area_set;
		logic ds2;
		logic ds1;
		logic unlock;
	} event_s;

endpackage

// file: contact_qualifier.sv
// Purpose: qualifies one contact input by a minimum closed time
// Assumes: contact input synchronous to clk_sys
// Notes: opening drops the level at once; only closure is filtered
`timescale 1ns/1ps
`default_nettype none
module contact_qualifier #(
	parameter int unsigned HOLD = contact_map_pkg::HOLD_CYCLES
) (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic contact_input,
	output var  logic level,
	output var  logic rise
);
	localparam int unsigned CNT_W = $clog2(HOLD + 1);
	localparam logic [CNT_W-1:0] LAST = CNT_W'(HOLD - 1);

	logic [CNT_W-1:0] cnt_reg;

	// ***************************************************************
	// closed-time counter
	// ***************************************************************
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cnt_reg <= '0;
			level   <= 1'b0;
		end else if (!contact_input) begin
			cnt_reg <= '0;
			level   <= 1'b0;
		end else if (!level) begin
			cnt_reg <= cnt_reg + CNT_W'(1);
			if (cnt_reg == LAST) begin
				level <= 1'b1;
			end
		end
	end

	// ***************************************************************
	// validated edge
	// ***************************************************************
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rise <= 1'b0;
		end else begin
			rise <= contact_input && !level && (cnt_reg == LAST);
		end
	end
endmodule
`default_nettype wire

// file: contact_input_function_mapper.sv
// Purpose: maps eight qualified contact inputs to controller functions
// Assumes: AXI4-Lite slave, one clock, synchronous active-high reset
// Notes: assignment setting picks one row of the function table
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module contact_input_function_mapper #(
	parameter int unsigned HOLD = contact_map_pkg::HOLD_CYCLES,
	parameter int unsigned NUM  = contact_map_pkg::NUM_INPUTS
) (
	input  wire logic                                   clk_sys,
	input  wire logic                                   rst,
	input  wire logic [NUM-1:0]                         contact_input,
	output var  contact_map_pkg::mode_s                 mode,
	output var  contact_map_pkg::event_s                pulses,
	input  wire logic [contact_map_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                                   s_axi_awvalid,
	output logic                                        s_axi_awready,
	input  wire logic [31:0]                            s_axi_wdata,
	input  wire logic [3:0]                             s_axi_wstrb,
	input  wire logic                                   s_axi_wvalid,
	output logic                                        s_axi_wready,
	output var  logic [1:0]                             s_axi_bresp,
	output var  logic                                   s_axi_bvalid,
	input  wire logic                                   s_axi_bready,
	input  wire logic [contact_map_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                                   s_axi_arvalid,
	output logic                                        s_axi_arready,
	output var  logic [31:0]                            s_axi_rdata,
	output var  logic [1:0]                             s_axi_rresp,
	output var  logic                                   s_axi_rvalid,
	input  wire logic                                   s_axi_rready
);
	localparam int unsigned AW = contact_map_pkg::AXI_ADDR_W;
	localparam int unsigned SW = contact_map_pkg::SET_W;

	// ***************************************************************
	// helpers
	// ***************************************************************
	function automatic contact_map_pkg::func_e func_of(
		input logic [SW-1:0] setting,
		input int unsigned   idx
	);
		logic [31:0] row;
		row = 32'h00000000;
		if (32'(setting) <= contact_map_pkg::MAX_SETTING) begin
			row = contact_map_pkg::ASSIGN_TABLE[setting];
		end
		return contact_map_pkg::func_e'(row[4*idx +: 4]);
	endfunction

	function automatic logic [31:0] strobe_merge(
		input logic [31:0] old,
		input logic [31:0] data,
		input logic [3:0]  strb
	);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = data[8*b +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic [AW-1:0] word_of(input logic [AW-1:0] a);
		return {a[AW-1:2], 2'b00};
	endfunction

	// ***************************************************************
	// software state
	// ***************************************************************
	logic [SW-1:0]                    setting_reg;
	logic                             area_en_reg;
	logic                             comm_run_reg;
	logic                             comm_manual_reg;
	logic                             comm_remote_reg;
	logic [contact_map_pkg::EVENT_W-1:0] event_reg;

	// ***************************************************************
	// input qualification
	// ***************************************************************
	logic [NUM-1:0] level;
	logic [NUM-1:0] rise;
	contact_map_pkg::func_e fn [NUM];

	genvar gi;
	generate
		for (gi = 0; gi < NUM; gi++) begin : g_in
			contact_qualifier #(
				.HOLD (HOLD)
			) u_qual (
				.clk_sys       (clk_sys),
				.rst           (rst),
				.contact_input (contact_input[gi]),
				.level         (level[gi]),
				.rise          (rise[gi])
			);
			assign fn[gi] = func_of(setting_reg, gi);
		end
	endgenerate

	// ***************************************************************
	// function decode
	// ***************************************************************
	logic       run_asg;
	logic       run_lvl;
	logic       man_asg;
	logic       man_lvl;
	logic       rem_asg;
	logic       rem_lvl;
	logic       soak_lvl;
	logic [2:0] area_bits;
	logic [1:0] opm_bits;
	logic       unlock_hit;
	logic       ds1_hit;
	logic       ds2_hit;
	logic       area_set_hit;

	always_comb begin
		run_asg      = 1'b0;
		run_lvl      = 1'b0;
		man_asg      = 1'b0;
		man_lvl      = 1'b0;
		rem_asg      = 1'b0;
		rem_lvl      = 1'b0;
		soak_lvl     = 1'b0;
		area_bits    = 3'h0;
		opm_bits     = 2'h0;
		unlock_hit   = 1'b0;
		ds1_hit      = 1'b0;
		ds2_hit      = 1'b0;
		area_set_hit = 1'b0;
		for (int i = 0; i < NUM; i++) begin
			case (fn[i])
				contact_map_pkg::FN_RUN: begin
					run_asg = 1'b1;
					run_lvl = run_lvl | level[i];
				end
				contact_map_pkg::FN_MANUAL: begin
					man_asg = 1'b1;
					man_lvl = man_lvl | level[i];
				end
				contact_map_pkg::FN_REMOTE: begin
					rem_asg = 1'b1;
					rem_lvl = rem_lvl | level[i];
				end
				contact_map_pkg::FN_UNLOCK: begin
					unlock_hit = unlock_hit | rise[i];
				end
				contact_map_pkg::FN_DS1: begin
					ds1_hit = ds1_hit | rise[i];
				end
				contact_map_pkg::FN_DS2: begin
					ds2_hit = ds2_hit | rise[i];
				end
				contact_map_pkg::FN_SOAK: begin
					soak_lvl = soak_lvl | level[i];
				end
				contact_map_pkg::FN_AREA8: begin
					if (i < 3) begin
						area_bits[i % 3] = level[i];
					end
				end
				contact_map_pkg::FN_AREA2: begin
					area_bits[0] = level[i];
				end
				contact_map_pkg::FN_AREASET: begin
					area_set_hit = area_set_hit | rise[i];
				end
				contact_map_pkg::FN_OPMODE: begin
					opm_bits[i % 2] = level[i];
				end
				default: begin
				end
			endcase
		end
	end

	// ***************************************************************
	// mode outputs
	// ***************************************************************
	// without a run contact the communication request alone decides
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mode <= '0;
		end else begin
			mode.run       <= (run_asg ? run_lvl : 1'b1) & comm_run_reg;
			mode.manual    <= man_asg ? man_lvl : comm_manual_reg;
			mode.remote    <= rem_asg ? rem_lvl : comm_remote_reg;
			mode.soak_stop <= soak_lvl;
			mode.area      <= area_bits;
			mode.op_mode   <= opm_bits;
		end
	end

	// ***************************************************************
	// edge outputs
	// ***************************************************************
	logic [contact_map_pkg::EVENT_W-1:0] ev_set;

	assign ev_set = {area_set_hit & area_en_reg, ds2_hit, ds1_hit, unlock_hit};

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pulses <= '0;
		end else begin
			pulses.unlock   <= unlock_hit;
			pulses.ds1      <= ds1_hit;
			pulses.ds2      <= ds2_hit;
			pulses.area_set <= area_set_hit & area_en_reg;
		end
	end

	// ***************************************************************
	// write channel
	// ***************************************************************
	logic          aw_hold_reg;
	logic          w_hold_reg;
	logic [AW-1:0] awaddr_reg;
	logic [31:0]   wdata_reg;
	logic [3:0]    wstrb_reg;
	logic          aw_hs;
	logic          w_hs;
	logic          wr_fire;
	logic [AW-1:0] wr_addr;
	logic [31:0]   wr_data;
	logic [3:0]    wr_strb;
	logic [31:0]   ctrl_word;
	logic [31:0]   ctrl_new;

	assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;
	assign aw_hs   = s_axi_awvalid && s_axi_awready;
	assign w_hs    = s_axi_wvalid && s_axi_wready;
	assign wr_fire = (aw_hold_reg || aw_hs) && (w_hold_reg || w_hs);
	assign wr_addr = word_of(aw_hold_reg ? awaddr_reg : s_axi_awaddr);
	assign wr_data = w_hold_reg ? wdata_reg : s_axi_wdata;
	assign wr_strb = w_hold_reg ? wstrb_reg : s_axi_wstrb;
	assign ctrl_new = strobe_merge(ctrl_word, wr_data, wr_strb);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg  <= 1'b0;
			awaddr_reg  <= '0;
			wdata_reg   <= 32'h00000000;
			wstrb_reg   <= 4'h0;
		end else begin
			aw_hold_reg <= (aw_hold_reg || aw_hs) && !wr_fire;
			w_hold_reg  <= (w_hold_reg || w_hs) && !wr_fire;
			if (aw_hs) begin
				awaddr_reg <= s_axi_awaddr;
			end
			if (w_hs) begin
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= contact_map_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (wr_addr == contact_map_pkg::OFF_CTRL ||
				wr_addr == contact_map_pkg::OFF_EVENT) ?
				contact_map_pkg::RESP_OKAY : contact_map_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ***************************************************************
	// control register
	// ***************************************************************
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			setting_reg     <= contact_map_pkg::SET_RESET;
			area_en_reg     <= contact_map_pkg::AREA_EN_RESET;
			comm_run_reg    <= contact_map_pkg::COMM_RUN_RESET;
			comm_manual_reg <= contact_map_pkg::COMM_MANUAL_RESET;
			comm_remote_reg <= contact_map_pkg::COMM_REMOTE_RESET;
		end else if (wr_fire && wr_addr == contact_map_pkg::OFF_CTRL) begin
			setting_reg     <= ctrl_new[contact_map_pkg::CTRL_SET_LSB +: SW];
			area_en_reg     <= ctrl_new[contact_map_pkg::CTRL_AREA_EN_BIT];
			comm_run_reg    <= ctrl_new[contact_map_pkg::CTRL_RUN_BIT];
			comm_manual_reg <= ctrl_new[contact_map_pkg::CTRL_MANUAL_BIT];
			comm_remote_reg <= ctrl_new[contact_map_pkg::CTRL_REMOTE_BIT];
		end
	end

	// ***************************************************************
	// sticky event register
	// ***************************************************************
	// a new edge in the clearing cycle survives the clear
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			event_reg <= '0;
		end else if (wr_fire && wr_addr == contact_map_pkg::OFF_EVENT) begin
			event_reg <= (event_reg & ~(wr_data[3:0] & {4{wr_strb[0]}})) | ev_set;
		end else begin
			event_reg <= event_reg | ev_set;
		end
	end

	// ***************************************************************
	// read channel
	// ***************************************************************
	logic [31:0] stat_word;
	logic [AW-1:0] rd_addr;

	always_comb begin
		ctrl_word = 32'h00000000;
		ctrl_word[contact_map_pkg::CTRL_SET_LSB +: SW]  = setting_reg;
		ctrl_word[contact_map_pkg::CTRL_AREA_EN_BIT]    = area_en_reg;
		ctrl_word[contact_map_pkg::CTRL_RUN_BIT]        = comm_run_reg;
		ctrl_word[contact_map_pkg::CTRL_MANUAL_BIT]     = comm_manual_reg;
		ctrl_word[contact_map_pkg::CTRL_REMOTE_BIT]     = comm_remote_reg;
	end

	always_comb begin
		stat_word = 32'h00000000;
		stat_word[contact_map_pkg::STAT_LEVEL_LSB +: NUM] = level;
		stat_word[contact_map_pkg::STAT_MODE_LSB +: $bits(mode)] = mode;
	end

	assign s_axi_arready = !s_axi_rvalid;
	assign rd_addr = word_of(s_axi_araddr);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= contact_map_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= contact_map_pkg::RESP_OKAY;
			case (rd_addr)
				contact_map_pkg::OFF_CTRL: begin
					s_axi_rdata <= ctrl_word;
				end
				contact_map_pkg::OFF_STATUS: begin
					s_axi_rdata <= stat_word;
				end
				contact_map_pkg::OFF_EVENT: begin
					s_axi_rdata <= {28'h0000000, event_reg};
				end
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= contact_map_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// file: contact_bank.sv
// Purpose: dry contact bank driving the eight mapper inputs
// Assumes: want changes right after a rising clk_sys edge
// Notes: chatter flips changed contacts back a few times before settling
`timescale 1ns/1ps
`default_nettype none
module contact_bank (
	input  wire logic       clk_sys,
	input  wire logic [7:0] want,
	input  wire logic       chatter,
	output var  logic [7:0] contact_input
);
	logic [7:0] now_reg;
	logic [7:0] diff_reg;
	logic [2:0] bounce_reg;
	initial begin
		now_reg = 8'h00;
		diff_reg = 8'h00;
		bounce_reg = 3'h0;
		contact_input = 8'h00;
	end
	// bounce must never pass for closed time
	always @(posedge clk_sys) begin
		if (want != now_reg) begin
			now_reg <= want;
			diff_reg <= want ^ now_reg;
			bounce_reg <= chatter ? 3'h5 : 3'h0;
		end else if (bounce_reg != 3'h0)
			bounce_reg <= bounce_reg - 3'h1;
		contact_input <= now_reg ^ (bounce_reg[0] ? diff_reg : 8'h00);
	end
endmodule
`default_nettype wire

// file: contact_mapper_props.sv
// Purpose: port-level checks for the contact input function mapper
// Assumes: one clock, synchronous active-high reset
// Notes: closure counters rebuild the hold timing from the pins
`timescale 1ns/1ps
`default_nettype none
module contact_mapper_props #(
	parameter int unsigned HOLD = 20
) (
	input wire logic                    clk_sys,
	input wire logic                    rst,
	input wire logic [7:0]              contact_input,
	input wire logic [3:0]              s_axi_awaddr,
	input wire contact_map_pkg::mode_s  mode,
	input wire contact_map_pkg::event_s pulses,
	input wire logic                    s_axi_awvalid,
	input wire logic                    s_axi_awready,
	input wire logic [31:0]             s_axi_wdata,
	input wire logic                    s_axi_wvalid,
	input wire logic                    s_axi_wready,
	input wire logic                    s_axi_bvalid,
	input wire logic                    s_axi_arvalid,
	input wire logic                    s_axi_arready,
	input wire logic                    s_axi_rvalid
);
	logic [31:0] cnt_reg [8];
	logic        held;
	logic        en_seen_reg;
	logic        written_reg;
	logic        aw_ctrl_reg;
	logic        w_en_reg;
	logic        b_was_reg;
	// counters saturate so long closures cannot wrap
	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < 8; i++) begin
			if (rst || !contact_input[i])
				cnt_reg[i] <= 32'h0;
			else if (cnt_reg[i] < HOLD)
				cnt_reg[i] <= cnt_reg[i] + 32'h1;
		end
	end
	always_comb begin
		held = 1'b0;
		for (int i = 0; i < 8; i++)
			if (cnt_reg[i] >= HOLD)
				held = 1'b1;
	end
	// enable follows the last control write, a cycle behind the design
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			en_seen_reg <= 1'b0;
			written_reg <= 1'b0;
			aw_ctrl_reg <= 1'b0;
			w_en_reg    <= 1'b0;
			b_was_reg   <= 1'b0;
		end else begin
			b_was_reg <= s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready)
				aw_ctrl_reg <= (s_axi_awaddr[3:2] == 2'b00);
			if (s_axi_wvalid && s_axi_wready) begin
				written_reg <= 1'b1;
				w_en_reg    <= s_axi_wdata[8];
			end
			if (s_axi_bvalid && !b_was_reg && aw_ctrl_reg)
				en_seen_reg <= w_en_reg;
		end
	end
	// ****************
	// properties
	// ****************
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	property p_unlock_once; pulses.unlock |=> !pulses.unlock; endproperty
	property p_ds1_once; pulses.ds1 |=> !pulses.ds1; endproperty
	property p_ds2_once; $rose(pulses.ds2) |=> $fell(pulses.ds2); endproperty
	property p_held; (|pulses) |-> $past(held); endproperty
	property p_soak; $rose(mode.soak_stop) |-> $past(held); endproperty
	property p_area_gate; pulses.area_set |-> en_seen_reg; endproperty
	property p_idle; !written_reg |-> (mode == '0) && (pulses == '0); endproperty
	property p_wr_answer;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|=> s_axi_bvalid && !s_axi_awready && !s_axi_wready;
	endproperty
	property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
	a_unlock_once: assert property (p_unlock_once) else $error("release pulse too long");
	a_ds1_once: assert property (p_ds1_once) else $error("trigger 1 pulse too long");
	a_ds2_once: assert property (p_ds2_once) else $error("trigger 2 pulse too long");
	a_held: assert property (p_held) else $error("pulse without full closure");
	a_soak: assert property (p_soak) else $error("soak stop without full closure");
	a_area_gate: assert property (p_area_gate) else $error("area set while disabled");
	a_idle: assert property (p_idle) else $error("outputs move before setup");
	a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
	a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
	c_ds2: cover property (pulses.ds2);
	c_area: cover property (pulses.area_set);
	c_soak: cover property ($rose(mode.soak_stop));
endmodule
bind contact_input_function_mapper contact_mapper_props #(.HOLD(HOLD)) u_contact_mapper_props (
	.clk_sys(clk_sys), .rst(rst), .contact_input(contact_input), .mode(mode), .pulses(pulses),
	.s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid)
);
`default_nettype wire

// file: contact_input_function_mapper_tb.sv
// Purpose: self-checking bench for the contact input function mapper
// Assumes: short hold parameter, register access over AXI4-Lite
// Notes: bus answers are checked against a queue of notes
`timescale 1ns/1ps
`default_nettype none
module contact_input_function_mapper_tb;
	localparam int unsigned HOLD = 20;
	localparam logic [3:0] CT = contact_map_pkg::OFF_CTRL;
	localparam logic [3:0] ST = contact_map_pkg::OFF_STATUS;
	localparam logic [3:0] EV = contact_map_pkg::OFF_EVENT;
	localparam logic [1:0] OK = contact_map_pkg::RESP_OKAY;
	localparam logic [1:0] ER = contact_map_pkg::RESP_SLVERR;
	localparam logic [4:0] SETS [3] = '{5'h01, 5'h02, 5'h05};
	localparam logic [8:0] SHUT [3] = '{9'h180, 9'h140, 9'h100};
	localparam logic [8:0] OPEN [3] = '{9'h140, 9'h180, 9'h0C0};
	logic                    clk_sys, rst, chatter;
	logic [7:0]              want, contact_input, v;
	contact_map_pkg::mode_s  mode;
	contact_map_pkg::event_s pulses;
	logic [3:0]              s_axi_awaddr, s_axi_araddr;
	logic [31:0]             s_axi_wdata, s_axi_rdata;
	logic [1:0]              s_axi_bresp, s_axi_rresp;
	logic                    s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic                    s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic                    s_axi_rvalid, s_axi_rready;
	logic [33:0]             exp_q [$];
	logic [33:0]             got, exp_n;
	int                      bad_count, n_tests;
	logic [3:0]              seen;
	contact_bank u_contact_bank (.clk_sys(clk_sys), .want(want), .chatter(chatter),
		.contact_input(contact_input));
	contact_input_function_mapper #(.HOLD(HOLD)) u_contact_input_function_mapper (
		.clk_sys(clk_sys), .rst(rst), .contact_input(contact_input), .mode(mode), .pulses(pulses),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
	// ****************
	// bus and checks
	// ****************
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic give_up(input int n);
		if (n >= 50) begin
			bad_count++;
			$display("wrong value at %0t: no bus answer", $time);
			close_out();
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
		int n;
		n = 0;
		exp_q.push_back({32'h0, e});
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
				s_axi_bready <= 1'b0;
		end while (s_axi_bready && n < 50);
		give_up(n);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
		int n;
		n = 0;
		exp_q.push_back({d, e});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
				s_axi_rready <= 1'b0;
		end while (s_axi_rready && n < 50);
		give_up(n);
	endtask
	task automatic wait_cy(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic saw(input logic [3:0] e);
		n_tests++;
		if (seen !== e) begin
			bad_count++;
			$display("wrong value at %0t: pulses seen %h", $time, seen);
		end
	endtask
	// pulses last one cycle, so they are gathered for the event checks
	always @(posedge clk_sys)
		seen <= rst ? 4'h0 : (seen | pulses);
	// write answers carry zero data, so one note layout serves both
	always @(posedge clk_sys) begin
		if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready)) begin
			got = s_axi_rvalid ? {s_axi_rdata, s_axi_rresp} : {32'h0, s_axi_bresp};
			exp_n = (exp_q.size() != 0) ? exp_q.pop_front() : 'x;
			n_tests++;
			if (got !== exp_n) begin
				bad_count++;
				$display("wrong value at %0t: got %h expected %h", $time, got, exp_n);
			end
		end
	end
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	initial begin
		{rst, chatter, want} = {2'b11, 8'h00};
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		bad_count = 0;
		n_tests = 0;
		void'($urandom(32'hE8C2B00A));
		wait_cy(2);
		rst <= 1'b0;
		want <= 8'hFF;
		wait_cy(HOLD + 10);
		rd(ST, 32'h000000FF, OK);
		rd(EV, 32'h0, OK);
		rd(CT, 32'h0, OK);
		rd(4'hC, 32'h0, ER);
		wr(ST, 32'hFFFFFFFF, ER);
		want <= 8'h00;
		chatter <= 1'b0;
		wr(CT, 32'h3, OK);
		wait_cy(6);
		want <= 8'h80;
		wait_cy(HOLD - 1);
		want <= 8'h00;
		wait_cy(6);
		rd(EV, 32'h0, OK);
		want <= 8'h80;
		wait_cy(HOLD);
		want <= 8'h00;
		wait_cy(6);
		rd(EV, 32'h2, OK);
		saw(4'h2);
		wr(EV, 32'hF, OK);
		rd(EV, 32'h0, OK);
		chatter <= 1'b1;
		wr(CT, 32'h4, OK);
		repeat (4) begin
			v = (8'($urandom) & 8'h37) | 8'h80;
			want <= v;
			wait_cy(HOLD + 10);
			rd(ST, {15'h0, 4'h1, v[2:0], v[5:4], v}, OK);
		end
		want <= 8'h48;
		wait_cy(HOLD + 10);
		rd(EV, 32'h1, OK);
		saw(4'h3);
		wr(EV, 32'hF, OK);
		wr(CT, 32'h104, OK);
		rd(CT, 32'h104, OK);
		want <= 8'h40;
		wait_cy(4);
		want <= 8'h48;
		wait_cy(HOLD + 10);
		rd(EV, 32'h8, OK);
		saw(4'hB);
		want <= 8'h00;
		wait_cy(12);
		wr(EV, 32'hF, OK);
		wr(CT, 32'h0005001C, OK);
		want <= 8'h99;
		wait_cy(HOLD + 10);
		rd(ST, 32'h00018499, OK);
		rd(EV, 32'h4, OK);
		saw(4'hF);
		wr(CT, 32'h0004001C, OK);
		wait_cy(4);
		rd(ST, 32'h00008499, OK);
		want <= 8'h00;
		wait_cy(12);
		for (int i = 0; i < 3; i++) begin
			wr(CT, {13'h0, 3'h1, 11'h0, SETS[i]}, OK);
			want <= 8'h80;
			wait_cy(HOLD + 10);
			rd(ST, {15'h0, SHUT[i], 8'h80}, OK);
			wr(CT, {13'h0, 3'h7, 11'h0, SETS[i]}, OK);
			want <= 8'h00;
			wait_cy(12);
			rd(ST, {15'h0, OPEN[i], 8'h00}, OK);
		end
		close_out();
	end
endmodule
`default_nettype wire
